// file: hw/tws_pkg.sv
package tws_pkg;

    // register index on the plain register port
    localparam int          REG_AW                  = 3;
    localparam logic [2:0]  OFS_MODULE_CONTROL      = 3'h0;
    localparam logic [2:0]  OFS_BUS_STATUS_CONTROL  = 3'h1;
    localparam logic [2:0]  OFS_OWN_SLAVE_ADDRESS   = 3'h2;
    localparam logic [2:0]  OFS_SHARED_DATA_BYTE    = 3'h3;
    localparam logic [2:0]  OFS_BUS_TIMEOUT_CONTROL = 3'h4;
    localparam logic [2:0]  OFS_PIN_PULLUP          = 3'h5;

    // module_control fields
    localparam int          MC_MODE_LSB   = 5;
    localparam int          MC_UNUSED_BIT = 4;
    localparam int          MC_DEB_LSB    = 2;
    localparam int          MC_EN_BIT     = 1;
    localparam int          MC_ICF_BIT    = 0;

    // bus_status_control fields
    localparam int          BS_DONE_BIT   = 7;
    localparam int          BS_AMATCH_BIT = 6;
    localparam int          BS_BUSY_BIT   = 5;
    localparam int          BS_HTX_BIT    = 4;
    localparam int          BS_ACK_TO_SEND_BIT   = 3;
    localparam int          BS_RW_BIT     = 2;
    localparam int          BS_WAKE_BIT   = 1;
    localparam int          BS_RXACK_BIT  = 0;

    // reset values
    localparam logic [2:0]  MODE_RST      = 3'h7;
    localparam logic [1:0]  DEB_RST       = 2'h0;
    localparam logic        DONE_RST      = 1'b1;
    localparam logic        RXACK_RST     = 1'b1;
    localparam logic [1:0]  LINE_IDLE     = 2'h3;

    // function modes
    localparam logic [2:0]  MODE_SPI_SLAVE       = 3'h5;
    localparam logic [2:0]  MODE_TWO_WIRE_SLAVE  = 3'h6;
    localparam logic [2:0]  MODE_OFF             = 3'h7;

    // debounce selections and their lengths in system clocks
    localparam logic [1:0]  DEB_SEL_NONE  = 2'h0;
    localparam logic [1:0]  DEB_SEL_TWO   = 2'h1;
    localparam logic [2:0]  DEB_CNT_NONE  = 3'h0;
    localparam logic [2:0]  DEB_CNT_TWO   = 3'h2;
    localparam logic [2:0]  DEB_CNT_FOUR  = 3'h4;

    // line indices
    localparam int          LINE_SCL      = 0;
    localparam int          LINE_SDA      = 1;
    localparam logic [3:0]  BITS_PER_BYTE = 4'h8;

    typedef enum logic [3:0] {
        ST_IDLE,
        ST_ADDR,
        ST_ADDR_ACK,
        ST_HOLD,
        ST_RX,
        ST_RX_ACK,
        ST_TX,
        ST_TX_ACK,
        ST_WAIT
    } tws_state_e;

endpackage : tws_pkg

// file: hw/tws_slave.sv
// The strobed register port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
// Function
// [R1] only slave role: slave transmit and slave receive byte transfers
// [R2] data and clock lines only ever pulled low, open-drain
// [R3] no select pin; selection purely by address on the bus
// [R4] own address in bits 7..1, bit 0 plain read/write storage
// [R5] address equal to own address selects this slave for the transfer
// [R6] clock glitch filter: 00 none, 01 two clocks, 1x four clocks
// [R7] filter selection applies only in two-wire slave mode 110
// [R8] system clock must exceed minimum set by bus speed and filter
// [R9] 3-bit mode: spi master, spi slave 101, two-wire 110, off 111
// [R10] enable low releases lines and drops module activity
// [R11] enable bit effective only with configuration option enabled
// [R12] enable rising keeps direction and ack-to-send bits
// [R13] enable rising resets done, match, busy, read/write, received-ack flags
// [R14] all bus data passes through one shared data register
// [R15] own address shares location with spi second control register
// [R16] module control bit 4 reads zero
// [R17] pull-up controls stay effective while interface is active
// [R18] filter accepts a level only after stable for selected cycles
module tws_slave
    import tws_pkg::*;
#(
    parameter int DEBOUNCE_MAX = 4
) (
    // clock and reset
    input  wire logic              sys_clk,
    input  wire logic              sys_rst,
    // configuration option
    input  wire logic              cfg_option_enable,
    // register port
    input  wire logic [REG_AW-1:0] reg_addr,
    input  wire logic [7:0]        reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output logic      [7:0]        reg_rdata,
    // bus clock line
    input  wire logic              scl_in,
    output logic                   scl_out,
    output logic                   scl_oe,
    // bus data line
    input  wire logic              sda_in,
    output logic                   sda_out,
    output logic                   sda_oe,
    // pin pull-ups and activity
    output logic                   scl_pullup_en,
    output logic                   sda_pullup_en,
    output logic                   module_active
);

    // refused at elaboration: the debounce counter is three bits wide
    if (DEBOUNCE_MAX < int'(DEB_CNT_FOUR) || DEBOUNCE_MAX > 7) begin : g_bad_debounce
        $error("tws_slave: DEBOUNCE_MAX must be 4..7");
    end

    typedef struct packed {
        logic [1:0]      sync1;
        logic [1:0]      sync2;
        logic [1:0]      filt;
        logic [1:0][2:0] dcnt;
        logic [1:0]      prev;
        logic [2:0]      mode;
        logic [1:0]      deb;
        logic            en;
        logic            en_prev;
        logic            icf;
        logic            done;
        logic            amatch;
        logic            busy;
        logic            transmit_direction;
        logic            ack_to_send;
        logic            rw;
        logic            wake;
        logic            rxack;
        logic [7:0]      own;
        logic [7:0]      data;
        logic [7:0]      tout;
        logic [1:0]      pull;
        tws_state_e      st;
        logic [3:0]      bitcnt;
        logic [7:0]      shift;
        logic            sda_oe;
        logic            scl_oe;
        logic [1:0]      line_out;
        logic [7:0]      rdata;
        logic            active;
    } tws_regs_s;

    tws_regs_s q;
    tws_regs_s next_q;

    always_comb begin
        logic [2:0] thresh;
        logic       scl_rise;
        logic       scl_fall;
        logic       start_seen;
        logic       stop_seen;
        logic       run;
        logic       wr_data;
        logic       rd_data;
        logic [7:0] tx_byte;
        thresh     = DEB_CNT_NONE;
        scl_rise   = 1'b0;
        scl_fall   = 1'b0;
        start_seen = 1'b0;
        stop_seen  = 1'b0;
        run        = 1'b0;
        wr_data    = 1'b0;
        rd_data    = 1'b0;
        tx_byte    = 8'h00;
        next_q     = q;

        // two-flop synchronisers for both lines
        next_q.sync1 = {sda_in, scl_in};
        next_q.sync2 = q.sync1;

        // filter length, only honoured in two-wire mode
        if (q.mode == MODE_TWO_WIRE_SLAVE) begin // [R7]
            if (q.deb == DEB_SEL_NONE) begin // [R6]
                thresh = DEB_CNT_NONE;
            end else if (q.deb == DEB_SEL_TWO) begin
                thresh = DEB_CNT_TWO;
            end else begin
                thresh = DEB_CNT_FOUR;
            end
        end

        // both lines pass the same filter so data stays aligned with clock
        for (int i = 0; i < 2; i++) begin
            if (thresh == DEB_CNT_NONE) begin
                next_q.filt[i] = q.sync2[i];
                next_q.dcnt[i] = 3'h0;
            end else if (q.sync2[i] != q.filt[i]) begin
                if (3'(q.dcnt[i] + 3'h1) >= thresh) begin // [R18]
                    next_q.filt[i] = q.sync2[i];
                    next_q.dcnt[i] = 3'h0;
                end else begin
                    next_q.dcnt[i] = 3'(q.dcnt[i] + 3'h1);
                end
            end else begin
                next_q.dcnt[i] = 3'h0;
            end
        end
        next_q.prev = q.filt;

        scl_rise   = q.filt[LINE_SCL] & ~q.prev[LINE_SCL];
        scl_fall   = ~q.filt[LINE_SCL] & q.prev[LINE_SCL];
        start_seen = q.filt[LINE_SCL] & q.prev[LINE_SCL] & q.prev[LINE_SDA] & ~q.filt[LINE_SDA];
        stop_seen  = q.filt[LINE_SCL] & q.prev[LINE_SCL] & ~q.prev[LINE_SDA] & q.filt[LINE_SDA];

        run           = cfg_option_enable & q.en & (q.mode == MODE_TWO_WIRE_SLAVE); // [R9] [R11]
        next_q.active = cfg_option_enable & q.en; // [R10]
        wr_data       = reg_wr & (reg_addr == OFS_SHARED_DATA_BYTE);
        rd_data       = reg_rd & (reg_addr == OFS_SHARED_DATA_BYTE);
        tx_byte       = wr_data ? reg_wdata : q.data; // [R14]

        // register writes by software
        if (reg_wr) begin
            case (reg_addr)
                OFS_MODULE_CONTROL: begin
                    next_q.mode = reg_wdata[MC_MODE_LSB +: 3];
                    next_q.deb  = reg_wdata[MC_DEB_LSB +: 2];
                    next_q.en   = reg_wdata[MC_EN_BIT];
                    next_q.icf  = reg_wdata[MC_ICF_BIT];
                end
                OFS_BUS_STATUS_CONTROL: begin
                    next_q.transmit_direction  = reg_wdata[BS_HTX_BIT];
                    next_q.ack_to_send = reg_wdata[BS_ACK_TO_SEND_BIT];
                    next_q.wake = reg_wdata[BS_WAKE_BIT];
                end
                OFS_OWN_SLAVE_ADDRESS: begin
                    next_q.own = reg_wdata; // [R4] [R15]
                end
                OFS_SHARED_DATA_BYTE: begin
                    next_q.data = reg_wdata; // [R14]
                end
                OFS_BUS_TIMEOUT_CONTROL: begin
                    next_q.tout = reg_wdata;
                end
                OFS_PIN_PULLUP: begin
                    next_q.pull = reg_wdata[1:0];
                end
                default: begin
                end
            endcase
        end

        // bus engine; slave only, no master states exist
        if (!run) begin // [R10]
            next_q.st     = ST_IDLE;
            next_q.sda_oe = 1'b0;
            next_q.scl_oe = 1'b0;
        end else if (start_seen) begin // [R3]
            next_q.st     = ST_ADDR;
            next_q.bitcnt = 4'h0;
            next_q.busy   = 1'b1;
            next_q.amatch = 1'b0;
            next_q.sda_oe = 1'b0;
            next_q.scl_oe = 1'b0;
        end else if (stop_seen) begin
            next_q.st     = ST_IDLE;
            next_q.busy   = 1'b0;
            next_q.sda_oe = 1'b0;
            next_q.scl_oe = 1'b0;
        end else begin
            case (q.st) // [R1]
                ST_ADDR: begin
                    if (scl_rise) begin
                        next_q.shift  = {q.shift[6:0], q.filt[LINE_SDA]};
                        next_q.bitcnt = 4'(q.bitcnt + 4'h1);
                    end else if (scl_fall && q.bitcnt == BITS_PER_BYTE) begin
                        if (q.shift[7:1] == q.own[7:1]) begin // [R5]
                            next_q.amatch = 1'b1;
                            next_q.rw     = q.shift[0];
                            next_q.done   = 1'b1;
                            next_q.sda_oe = 1'b1; // [R2]
                            next_q.st     = ST_ADDR_ACK;
                        end else begin
                            next_q.st = ST_WAIT;
                        end
                    end
                end
                ST_ADDR_ACK, ST_RX_ACK: begin
                    if (scl_fall) begin
                        next_q.sda_oe = 1'b0;
                        next_q.scl_oe = 1'b1; // [R2]
                        next_q.st     = ST_HOLD;
                    end
                end
                ST_HOLD: begin
                    // clock held low until software touches the data byte
                    if (wr_data || rd_data) begin
                        next_q.done   = 1'b0;
                        next_q.scl_oe = 1'b0;
                        next_q.bitcnt = 4'h0;
                        if (q.transmit_direction) begin
                            next_q.shift  = tx_byte;
                            next_q.sda_oe = ~tx_byte[7];
                            next_q.st     = ST_TX;
                        end else begin
                            next_q.sda_oe = 1'b0;
                            next_q.st     = ST_RX;
                        end
                    end
                end
                ST_RX: begin
                    if (scl_rise) begin
                        next_q.shift  = {q.shift[6:0], q.filt[LINE_SDA]};
                        next_q.bitcnt = 4'(q.bitcnt + 4'h1);
                    end else if (scl_fall && q.bitcnt == BITS_PER_BYTE) begin
                        next_q.data   = q.shift; // [R14]
                        next_q.done   = 1'b1;
                        next_q.sda_oe = ~q.ack_to_send;
                        next_q.st     = ST_RX_ACK;
                    end
                end
                ST_TX: begin
                    if (scl_rise) begin
                        next_q.bitcnt = 4'(q.bitcnt + 4'h1);
                    end else if (scl_fall) begin
                        if (q.bitcnt == BITS_PER_BYTE) begin
                            next_q.sda_oe = 1'b0;
                            next_q.st     = ST_TX_ACK;
                        end else begin
                            next_q.shift  = {q.shift[6:0], 1'b0};
                            next_q.sda_oe = ~q.shift[6]; // [R2]
                        end
                    end
                end
                ST_TX_ACK: begin
                    if (scl_rise) begin
                        next_q.rxack = q.filt[LINE_SDA];
                        next_q.done  = 1'b1;
                    end else if (scl_fall) begin
                        if (!q.rxack) begin
                            next_q.scl_oe = 1'b1;
                            next_q.st     = ST_HOLD;
                        end else begin
                            next_q.st = ST_WAIT;
                        end
                    end
                end
                ST_IDLE, ST_WAIT: begin
                end
                default: begin
                    next_q.st = ST_IDLE;
                end
            endcase
        end

        // enable rising in two-wire mode: flags to defaults, controls kept
        next_q.en_prev = q.en;
        if (q.en && !q.en_prev && q.mode == MODE_TWO_WIRE_SLAVE) begin // [R12] [R13]
            next_q.done   = DONE_RST;
            next_q.amatch = 1'b0;
            next_q.busy   = 1'b0;
            next_q.rw     = 1'b0;
            next_q.rxack  = RXACK_RST;
        end

        // read data stands the cycle after the read strobe
        next_q.rdata = 8'h00;
        if (reg_rd) begin
            case (reg_addr)
                OFS_MODULE_CONTROL: begin
                    next_q.rdata = {q.mode, 1'b0, q.deb, q.en, q.icf}; // [R16]
                end
                OFS_BUS_STATUS_CONTROL: begin
                    next_q.rdata = {q.done, q.amatch, q.busy, q.transmit_direction, q.ack_to_send, q.rw, q.wake, q.rxack};
                end
                OFS_OWN_SLAVE_ADDRESS: begin
                    next_q.rdata = q.own;
                end
                OFS_SHARED_DATA_BYTE: begin
                    next_q.rdata = q.data;
                end
                OFS_BUS_TIMEOUT_CONTROL: begin
                    next_q.rdata = q.tout;
                end
                OFS_PIN_PULLUP: begin
                    next_q.rdata = {6'h00, q.pull};
                end
                default: begin
                    next_q.rdata = 8'h00;
                end
            endcase
        end
        next_q.line_out = 2'h0; // [R2]
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            q          <= '0;
            q.sync1    <= LINE_IDLE;
            q.sync2    <= LINE_IDLE;
            q.filt     <= LINE_IDLE;
            q.prev     <= LINE_IDLE;
            q.mode     <= MODE_RST;
            q.deb      <= DEB_RST;
            q.done     <= DONE_RST;
            q.rxack    <= RXACK_RST;
            q.st       <= ST_IDLE;
        end else begin
            q <= next_q;
        end
    end

    assign reg_rdata     = q.rdata;
    assign scl_out       = q.line_out[LINE_SCL];
    assign scl_oe        = q.scl_oe;
    assign sda_out       = q.line_out[LINE_SDA];
    assign sda_oe        = q.sda_oe;
    assign scl_pullup_en = q.pull[LINE_SCL]; // [R17]
    assign sda_pullup_en = q.pull[LINE_SDA]; // [R17]
    assign module_active = q.active;

endmodule : tws_slave

// file: dv/tws_bus_master.sv
`timescale 1ns/1ps
module tws_bus_master #(
    parameter int HALF_NS = 500
) (
    // resolved bus lines
    input  wire logic scl_line,
    input  wire logic sda_line,
    // pull-low drives
    output logic      scl_pull,
    output logic      sda_pull
);
    initial begin
        scl_pull = 1'b0;
        sda_pull = 1'b0;
    end

    // data set mid-low; the wait honours clock stretching by the slave
    task automatic bit_xfer(input logic b, output logic r);
        sda_pull = !b;
        #(HALF_NS / 2);
        scl_pull = 1'b0;
        wait (scl_line);
        #(HALF_NS / 2);
        r = sda_line;
        #(HALF_NS / 2);
        scl_pull = 1'b1;
        #(HALF_NS / 2);
    endtask : bit_xfer

    // sda falls while scl is high; the slave is then chosen by address only
    task automatic start_cond();
        sda_pull = 1'b0;
        scl_pull = 1'b0;
        wait (scl_line);
        #(HALF_NS);
        sda_pull = 1'b1;
        #(HALF_NS);
        scl_pull = 1'b1;
        #(HALF_NS / 2);
    endtask : start_cond

    task automatic stop_cond();
        sda_pull = 1'b1;
        #(HALF_NS / 2);
        scl_pull = 1'b0;
        wait (scl_line);
        #(HALF_NS);
        sda_pull = 1'b0;
        #(HALF_NS);
    endtask : stop_cond

    // msb first, ninth bit is the acknowledge
    task automatic byte_xfer(input logic [7:0] d, input logic ack_in, output logic [7:0] q, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            bit_xfer(d[i], q[i]);
        end
        bit_xfer(ack_in, ack);
    endtask : byte_xfer
endmodule : tws_bus_master

// file: dv/tws_slave_chk.sv
`timescale 1ns/1ps
module tws_slave_chk
    import tws_pkg::*;
#(
    parameter int DEBOUNCE_MAX = 4
) (
    // clock and reset
    input wire logic              sys_clk,
    input wire logic              sys_rst,
    // configuration and register port
    input wire logic              cfg_option_enable,
    input wire logic [REG_AW-1:0] reg_addr,
    input wire logic [7:0]        reg_wdata,
    input wire logic              reg_wr,
    input wire logic              reg_rd,
    input wire logic [7:0]        reg_rdata,
    // bus lines and pins
    input wire logic              scl_in,
    input wire logic              scl_out,
    input wire logic              scl_oe,
    input wire logic              sda_in,
    input wire logic              sda_out,
    input wire logic              sda_oe,
    input wire logic              scl_pullup_en,
    input wire logic              sda_pullup_en,
    input wire logic              module_active
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    sequence s_wr_rd(logic [2:0] idx);
        (reg_wr && reg_addr == idx) ##2 (reg_rd && reg_addr == idx);
    endsequence

    property p_open_drain;
        scl_out == 1'b0 && sda_out == 1'b0;
    endproperty
    property p_own_addr;
        s_wr_rd(OFS_OWN_SLAVE_ADDRESS) |=> reg_rdata == $past(reg_wdata, 3);
    endproperty
    property p_data_reg;
        s_wr_rd(OFS_SHARED_DATA_BYTE) |=> reg_rdata == $past(reg_wdata, 3);
    endproperty
    property p_bit4;
        reg_rd && reg_addr == OFS_MODULE_CONTROL |=> reg_rdata[MC_UNUSED_BIT] == 1'b0;
    endproperty
    property p_rdata_idle;
        !$past(reg_rd) |-> reg_rdata == 8'h00;
    endproperty
    property p_cfg_gate;
        !$past(cfg_option_enable) |-> !module_active;
    endproperty
    property p_released;
        !module_active [*3] |-> !scl_oe && !sda_oe;
    endproperty
    property p_sda_when_low;
        $changed(sda_oe) |-> !scl_in;
    endproperty
    property p_filter_lag;
        $fell(scl_in) && !sda_oe |=> !sda_oe ##1 !sda_oe;
    endproperty
    property p_pullup;
        reg_wr && reg_addr == OFS_PIN_PULLUP |-> ##2 {sda_pullup_en, scl_pullup_en} == $past(reg_wdata[1:0], 2);
    endproperty

    a_open_drain: assert property (p_open_drain) else $error("bus line driven high");
    a_own_addr: assert property (p_own_addr) else $error("own address readback wrong");
    a_data_reg: assert property (p_data_reg) else $error("data byte readback wrong");
    a_bit4: assert property (p_bit4) else $error("control bit 4 not zero");
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read slot");
    a_cfg_gate: assert property (p_cfg_gate) else $error("active without option");
    a_released: assert property (p_released) else $error("lines pulled while inactive");
    a_sda_when_low: assert property (p_sda_when_low) else $error("data changed with clock high");
    a_filter_lag: assert property (p_filter_lag) else $error("answer ahead of filter");
    a_pullup: assert property (p_pullup) else $error("pull-up control not applied");
endmodule : tws_slave_chk

// file: dv/tws_slave_test.sv
`timescale 1ns/1ps
module tws_slave_test;
    import tws_pkg::*;
    typedef struct packed {
        logic [2:0] addr;
        logic [7:0] wdata;
        logic [7:0] rdata;
    } tws_row_s;

    logic              sys_clk, sys_rst, cfg_option_enable, reg_wr, reg_rd;
    logic [REG_AW-1:0] reg_addr;
    logic [7:0]        reg_wdata, reg_rdata;
    logic              scl_out, scl_oe, sda_out, sda_oe, scl_pull, sda_pull;
    logic              scl_pullup_en, sda_pullup_en, module_active;
    int                mismatches, n_tests;
    wire logic         scl_line = !(scl_oe | scl_pull);
    wire logic         sda_line = !(sda_oe | sda_pull);
    tws_row_s          rows [9] = '{'{3'h0, 8'hff, 8'hef}, '{3'h0, 8'he0, 8'he0}, '{3'h1, 8'hff, 8'h9b},
                                    '{3'h1, 8'h00, 8'h81}, '{3'h2, 8'ha1, 8'ha1}, '{3'h3, 8'h3c, 8'h3c},
                                    '{3'h4, 8'h5a, 8'h5a}, '{3'h5, 8'h03, 8'h03}, '{3'h6, 8'hff, 8'h00}};

    tws_slave #(.DEBOUNCE_MAX(4)) tws_slave_i (
        .sys_clk(sys_clk), .sys_rst(sys_rst), .cfg_option_enable(cfg_option_enable), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .scl_in(scl_line),
        .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe),
        .scl_pullup_en(scl_pullup_en), .sda_pullup_en(sda_pullup_en), .module_active(module_active));
    tws_bus_master #(.HALF_NS(500)) tws_bus_master_i (
        .scl_line(scl_line), .sda_line(sda_line), .scl_pull(scl_pull), .sda_pull(sda_pull));

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge sys_clk);
        reg_wr    <= 1'b0;
    endtask : wr

    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge sys_clk);
        reg_rd   <= 1'b0;
        @(negedge sys_clk);
        d = reg_rdata;
    endtask : rd

    // the data byte releases the clock only once it is held, so wait for the stretch too
    task automatic wait_bit(input int b);
        logic [7:0] d;
        d = 8'h00;
        for (int i = 0; i < 3000 && (d[b] !== 1'b1 || scl_oe !== 1'b1); i++) rd(OFS_BUS_STATUS_CONTROL, d);
        check({7'h00, d[b]}, 8'h01);
    endtask : wait_bit

    // disable first so that the enable edge clears the flags
    task automatic setup(input logic [2:0] mode, input logic [1:0] deb);
        wr(OFS_MODULE_CONTROL, {mode, 1'b0, deb, 2'b00});
        wr(OFS_BUS_STATUS_CONTROL, 8'h00);
        wr(OFS_MODULE_CONTROL, {mode, 1'b0, deb, 2'b10});
    endtask : setup

    task automatic complete_run();
        if (mismatches == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : complete_run

    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end

    initial begin
        #1_000_000;
        mismatches++;
        complete_run();
    end

    initial begin
        logic [7:0] d, q;
        logic       ack;
        {sys_rst, cfg_option_enable, reg_wr, reg_rd, reg_addr, reg_wdata} = {2'b11, 2'b00, 3'h0, 8'h00};
        {mismatches, n_tests} = '0;
        repeat (3) @(posedge sys_clk);
        sys_rst <= 1'b0;
        foreach (rows[i]) begin
            wr(rows[i].addr, rows[i].wdata);
            rd(rows[i].addr, d);
            check(d, rows[i].rdata);
        end
        @(posedge sys_clk) sys_rst <= 1'b1;
        repeat (3) @(posedge sys_clk);
        sys_rst <= 1'b0;
        for (int i = 0; i < 8; i++) begin
            rd(3'(i), d);
            check(d, i == 0 ? {MODE_RST, 1'b0, DEB_RST, 2'h0} : i == 1 ? {DONE_RST, 6'h0, RXACK_RST} : 8'h00);
        end
        wr(OFS_OWN_SLAVE_ADDRESS, 8'ha0);
        // slave receive under each filter setting
        for (int k = 0; k < 4; k++) begin
            setup(MODE_TWO_WIRE_SLAVE, 2'(k));
            fork
                begin
                    tws_bus_master_i.start_cond();
                    tws_bus_master_i.byte_xfer(8'ha0, 1'b1, q, ack);
                    check({7'h00, ack}, 8'h00);
                    tws_bus_master_i.byte_xfer(8'h5a ^ 8'(k), 1'b1, q, ack);
                    check({7'h00, ack}, 8'h00);
                    tws_bus_master_i.stop_cond();
                end
                begin
                    wait_bit(BS_AMATCH_BIT);
                    rd(OFS_BUS_STATUS_CONTROL, d);
                    check(d & 8'h64, 8'h60);
                    rd(OFS_SHARED_DATA_BYTE, d);
                    wait_bit(BS_DONE_BIT);
                    rd(OFS_SHARED_DATA_BYTE, d);
                    check(d, 8'h5a ^ 8'(k));
                end
            join
        end
        // enable edge keeps direction and ack bits, resets the flags
        wr(OFS_MODULE_CONTROL, 8'hc0);
        wr(OFS_BUS_STATUS_CONTROL, 8'h18);
        wr(OFS_MODULE_CONTROL, 8'hc2);
        rd(OFS_BUS_STATUS_CONTROL, d);
        check(d, 8'h99);
        // slave transmit, master ends with a nack
        setup(MODE_TWO_WIRE_SLAVE, 2'h1);
        fork
            begin
                tws_bus_master_i.start_cond();
                tws_bus_master_i.byte_xfer(8'ha1, 1'b1, q, ack);
                check({7'h00, ack}, 8'h00);
                tws_bus_master_i.byte_xfer(8'hff, 1'b1, q, ack);
                check(q, 8'hc3);
                tws_bus_master_i.stop_cond();
            end
            begin
                wait_bit(BS_AMATCH_BIT);
                rd(OFS_BUS_STATUS_CONTROL, d);
                check(d & 8'h04, 8'h04);
                wr(OFS_BUS_STATUS_CONTROL, 8'h10);
                wr(OFS_SHARED_DATA_BYTE, 8'hc3);
            end
        join
        // every other mode, option off, and a foreign address stay silent
        for (int m = 0; m < 9; m++) begin
            @(posedge sys_clk);
            cfg_option_enable <= (m != 8);
            setup(m == 8 ? MODE_TWO_WIRE_SLAVE : 3'(m), 2'h0);
            tws_bus_master_i.start_cond();
            tws_bus_master_i.byte_xfer(m == 6 ? 8'ha2 : 8'ha0, 1'b1, q, ack);
            check({7'h00, ack}, 8'h01);
            tws_bus_master_i.stop_cond();
        end
        complete_run();
    end
endmodule : tws_slave_test

bind tws_slave tws_slave_chk #(.DEBOUNCE_MAX(DEBOUNCE_MAX)) tws_slave_chk_i (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .cfg_option_enable(cfg_option_enable), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .scl_in(scl_in),
    .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
    .scl_pullup_en(scl_pullup_en), .sda_pullup_en(sda_pullup_en), .module_active(module_active));
